// [verilog/radio_fault_alert_engine.sv]
/*
  fault alert engine: last fault code, per-condition flags, legacy code
  mask and per-flag enable mask, driving one alert line toward the host.
  assumes fault event pulses from logic on CLK and an avalon-mm master
  that holds its request until waitrequest is low.
*/
`timescale 1ns/100ps

// Summary of operation
// - nonzero legacy mask selects legacy alert source
// - legacy alert sets on masked nonzero fault
// - only a fault code read clears legacy
// - mask write leaves legacy latch untouched
// - new fault overwrites the held code
// - overflow and write failure codes recorded
// - missing acknowledgement records its code
// - crc and sequence errors record codes
// - bad packet type records its code
// - legacy masking is a bitwise and
// - codes stored whatever the mask holds
// - every stored code also sets flag
// - standard alert equals flags and enable
// - flag or enable writes re-evaluate alert
// - other enabled flags keep alert asserted
// - alert level readable in line state
module radio_fault_alert_engine
  import fault_alert_pkg::*;
(
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  // fault event pulses, one per condition
  input  wire logic [NUM_FAULTS-1:0] FAULT_EVENT,
  // avalon-mm register slave
  input  wire logic [7:0]            AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [3:0]            AVS_BYTEENABLE,
  input  wire logic [31:0]           AVS_WRITEDATA,
  output logic      [31:0]           AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  // alert toward the host
  output logic                       FAULT_ALERT_LINE
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [CODE_W-1:0]     fault_code_r;       // last fault code
  logic [CODE_W-1:0]     fault_code_nxt;
  logic [CODE_W-1:0]     legacy_mask_r;      // legacy code mask
  logic [CODE_W-1:0]     legacy_mask_nxt;
  logic [NUM_FAULTS-1:0] flag_bits_r;        // per-condition flags
  logic [NUM_FAULTS-1:0] flag_bits_nxt;
  logic [NUM_FAULTS-1:0] flag_enable_r;      // per-flag enables
  logic [NUM_FAULTS-1:0] flag_enable_nxt;
  logic                  legacy_alert_r;     // legacy alert latch
  logic                  legacy_alert_nxt;
  logic                  ack_r;              // bus answer phase
  logic [31:0]           readdata_r;         // registered read data
  logic [31:0]           readdata_nxt;

  // -----------------------------------------------------------------
  // fault code mapping
  // -----------------------------------------------------------------
  logic [CODE_W-1:0]     new_code;           // code of this cycle's fault
  logic                  fault_any;          // any fault this cycle

  fault_code_map u_map (
    .event_v (FAULT_EVENT),
    .code    (new_code),
    .any     (fault_any)
  );

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  wire logic req        = AVS_READ | AVS_WRITE;          // request pending
  wire logic wr_take    = AVS_WRITE & ack_r;             // write takes effect now
  wire logic rd_take    = AVS_READ & ack_r;              // read is taken now
  wire logic hit_code   = AVS_ADDRESS == FAULT_CODE_OFS;
  wire logic hit_mask   = AVS_ADDRESS == LEGACY_MASK_OFS;
  wire logic hit_flags  = AVS_ADDRESS == FLAG_BITS_OFS;
  wire logic hit_enable = AVS_ADDRESS == FLAG_ENABLE_OFS;
  wire logic hit_line   = AVS_ADDRESS == LINE_STATE_OFS;
  wire logic lane0      = AVS_BYTEENABLE[0];              // registers live in byte 0
  wire logic wdat_keep  = wr_take & lane0;

  // -----------------------------------------------------------------
  // alert derivation
  // -----------------------------------------------------------------
  wire logic legacy_mode    = legacy_mask_r != '0;
  wire logic legacy_hit     = fault_any & ((new_code & legacy_mask_r) != '0);
  wire logic code_read      = rd_take & hit_code;
  wire logic standard_alert = (flag_bits_r & flag_enable_r) != '0;

  // line follows the selected scheme; legacy source is a register, standard source is decoded from registers
  assign FAULT_ALERT_LINE = legacy_mode ? legacy_alert_r : standard_alert;

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  // code register: any fault overwrites, mask plays no part
  assign fault_code_nxt = fault_any ? new_code : fault_code_r;

  // legacy latch: set wins over the read clear; mask writes do not touch it
  assign legacy_alert_nxt = legacy_hit ? 1'b1 : (code_read ? 1'b0 : legacy_alert_r);

  // mask and enable writes through byte lane 0
  assign legacy_mask_nxt = (wdat_keep & hit_mask) ? AVS_WRITEDATA[CODE_W-1:0] : legacy_mask_r;
  assign flag_enable_nxt = (wdat_keep & hit_enable) ? AVS_WRITEDATA[NUM_FAULTS-1:0] : flag_enable_r;

  // flags: written zeros clear, written ones keep, new faults set and win
  wire logic [NUM_FAULTS-1:0] flag_kept = (wdat_keep & hit_flags) ?
                                          (flag_bits_r & AVS_WRITEDATA[NUM_FAULTS-1:0]) : flag_bits_r;
  assign flag_bits_nxt = flag_kept | FAULT_EVENT;

  // read mux, unmapped addresses read zero
  always_comb begin
    readdata_nxt = '0;
    unique case (1'b1)
      hit_code:   readdata_nxt[CODE_W-1:0]     = fault_code_r;
      hit_mask:   readdata_nxt[CODE_W-1:0]     = legacy_mask_r;
      hit_flags:  readdata_nxt[NUM_FAULTS-1:0] = flag_bits_r;
      hit_enable: readdata_nxt[NUM_FAULTS-1:0] = flag_enable_r;
      hit_line:   readdata_nxt[LINE_ALERT_BIT] = FAULT_ALERT_LINE;
      default:    readdata_nxt                 = '0;
    endcase
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // fault state, cleared by reset except the enables, which reset to all ones
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      fault_code_r   <= FAULT_CODE_RST;
      legacy_mask_r  <= LEGACY_MASK_RST;
      flag_bits_r    <= FLAG_BITS_RST;
      flag_enable_r  <= FLAG_ENABLE_RST;
      legacy_alert_r <= 1'b0;
    end else begin
      fault_code_r   <= fault_code_nxt;
      legacy_mask_r  <= legacy_mask_nxt;
      flag_bits_r    <= flag_bits_nxt;
      flag_enable_r  <= flag_enable_nxt;
      legacy_alert_r <= legacy_alert_nxt;
    end
  end

  // bus answer: one wait cycle, then data stands at the taking edge
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ack_r      <= 1'b0;
      readdata_r <= '0;
    end else begin
      ack_r      <= req & ~ack_r;
      readdata_r <= (AVS_READ & ~ack_r) ? readdata_nxt : readdata_r;
    end
  end

  assign AVS_WAITREQUEST = req & ~ack_r;
  assign AVS_READDATA    = readdata_r;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  // bus request in its wait cycle
  sequence bus_wait_s;
    req && !ack_r;
  endsequence

  // bus answer cycle
  sequence bus_answer_s;
    !AVS_WAITREQUEST && ack_r;
  endsequence

  // flag register write that lands at this edge, no fault alongside
  sequence flag_write_s;
    wdat_keep && hit_flags && !fault_any;
  endsequence

  // enable register write that lands at this edge, no fault alongside
  sequence enable_write_s;
    wdat_keep && hit_enable && !fault_any;
  endsequence

  // line follows the scheme that the mask selects
  alert_source_a: assert property (
    @(posedge CLK) disable iff (RESET)
    FAULT_ALERT_LINE == ((legacy_mask_r != '0) ? legacy_alert_r : ((flag_bits_r & flag_enable_r) != '0)))
    else $error("alert line not from selected scheme");

  // a masked fault raises the legacy latch
  legacy_set_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (fault_any && ((new_code & legacy_mask_r) != '0)) |=> legacy_alert_r)
    else $error("legacy alert missed a masked fault");

  // the latch only falls after a code read
  legacy_clear_a: assert property (
    @(posedge CLK) disable iff (RESET)
    $fell(legacy_alert_r) |-> $past(rd_take && hit_code))
    else $error("legacy alert cleared without code read");

  // mask writes leave the latch alone
  mask_write_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (wr_take && hit_mask && !fault_any && !code_read) |=> $stable(legacy_alert_r))
    else $error("mask write changed legacy alert");

  // every fault replaces the held code
  code_store_a: assert property (
    @(posedge CLK) disable iff (RESET)
    fault_any |=> fault_code_r == $past(new_code))
    else $error("fault code not stored");

  // lowest condition stores its own code
  code_low_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (FAULT_EVENT == 8'h01) |=> fault_code_r == 8'h08)
    else $error("input overflow code wrong");

  // highest condition stores its own code
  code_high_a: assert property (
    @(posedge CLK) disable iff (RESET)
    FAULT_EVENT[NUM_FAULTS-1] |=> fault_code_r == 8'h44)
    else $error("packet type code wrong");

  // each fault leaves its flag set
  flag_set_a: assert property (
    @(posedge CLK) disable iff (RESET)
    fault_any |=> ((flag_bits_r & $past(FAULT_EVENT)) == $past(FAULT_EVENT)))
    else $error("fault did not set its flag");

  // written zeros clear flags, written ones keep them
  flag_clear_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (wdat_keep && hit_flags && !fault_any) |=> flag_bits_r == ($past(flag_bits_r) & $past(AVS_WRITEDATA[7:0])))
    else $error("flag write did not clear bits");

  // line state read returns the level of the request cycle
  line_read_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (bus_wait_s and (AVS_READ && hit_line)) ##1 bus_answer_s |-> AVS_READDATA[0] == $past(FAULT_ALERT_LINE))
    else $error("line state read wrong");

  // one wait cycle, then the answer
  bus_answer_a: assert property (
    @(posedge CLK) disable iff (RESET)
    bus_wait_s |=> !AVS_WAITREQUEST)
    else $error("bus answer late");

  // -----------------------------------------------------------------
  // standard scheme, byte lane and reset checks
  // -----------------------------------------------------------------
  // a flag write that keeps an enabled flag keeps the line up
  flag_keep_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (flag_write_s and (!legacy_mode && ((flag_bits_r & flag_enable_r & AVS_WRITEDATA[NUM_FAULTS-1:0]) != '0)))
      |=> FAULT_ALERT_LINE)
    else $error("line dropped with an enabled flag still set");

  // an enable write makes the line follow the new enables at once
  enable_eval_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (enable_write_s and !legacy_mode)
      |=> FAULT_ALERT_LINE == ((flag_bits_r & $past(AVS_WRITEDATA[NUM_FAULTS-1:0])) != '0))
    else $error("enable write not applied to the line");

  // writes without byte lane 0 change no register
  lane_ignore_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (wr_take && !lane0 && !fault_any) |=> $stable(flag_bits_r) && $stable(flag_enable_r) && $stable(legacy_mask_r))
    else $error("write without lane 0 took effect");

  // while reset stands, code, flags, mask and line are cleared
  reset_state_a: assert property (
    @(posedge CLK)
    (RESET && $past(RESET)) |-> (fault_code_r == FAULT_CODE_RST) && (flag_bits_r == FLAG_BITS_RST) &&
      (legacy_mask_r == LEGACY_MASK_RST) && !FAULT_ALERT_LINE)
    else $error("reset state not cleared");

  // -----------------------------------------------------------------
  // legacy scheme checks
  // -----------------------------------------------------------------
  // a code read with no fault alongside drops the latch
  read_clear_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (code_read && !legacy_hit) |=> !legacy_alert_r)
    else $error("code read left legacy alert set");

  // rewriting a live mask with a nonzero one keeps the line level
  mask_level_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (wr_take && hit_mask && legacy_mode && (AVS_WRITEDATA[CODE_W-1:0] != '0) && !fault_any)
      |=> $stable(FAULT_ALERT_LINE))
    else $error("mask write moved the alert line");

  // a fault that the mask blocks is stored all the same
  masked_store_a: assert property (
    @(posedge CLK) disable iff (RESET)
    (fault_any && legacy_mode && ((new_code & legacy_mask_r) == '0)) |=> fault_code_r == $past(new_code))
    else $error("masked fault code not stored");

endmodule

// [shared/fault_alert_pkg.sv]
/*
  constants shared by the fault alert engine and its code mapper:
  register byte offsets, reset values, fault codes and flag positions.
  assumes a 32-bit avalon-mm register slave with one aligned word per register.
*/
package fault_alert_pkg;

  // -----------------------------------------------------------------
  // register map (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [7:0] FAULT_CODE_OFS   = 8'h00;  // last fault code, read clears legacy alert
  localparam logic [7:0] LEGACY_MASK_OFS  = 8'h04;  // legacy code mask
  localparam logic [7:0] FLAG_BITS_OFS    = 8'h08;  // per-condition flags, write 0 clears
  localparam logic [7:0] FLAG_ENABLE_OFS  = 8'h0c;  // per-flag enable mask
  localparam logic [7:0] LINE_STATE_OFS   = 8'h10;  // line state, bit 0 is the alert line

  // -----------------------------------------------------------------
  // widths and field positions
  // -----------------------------------------------------------------
  localparam int         CODE_W           = 8;      // width of a fault code
  localparam int         NUM_FAULTS       = 8;      // number of fault conditions
  localparam int         LINE_ALERT_BIT   = 0;      // alert level in the line state word

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] FAULT_CODE_RST   = 8'h00;
  localparam logic [7:0] LEGACY_MASK_RST  = 8'h00;
  localparam logic [7:0] FLAG_BITS_RST    = 8'h00;
  localparam logic [7:0] FLAG_ENABLE_RST  = 8'hff;  // standard scheme live out of reset

  // -----------------------------------------------------------------
  // fault codes, one per flag position
  // -----------------------------------------------------------------
  localparam logic [7:0] host_in_overflow_code    = 8'h08;
  localparam logic [7:0] host_out_overflow_code   = 8'h09;
  localparam logic [7:0] reg_write_fail_code      = 8'h13;
  localparam logic [7:0] missing_ack_code         = 8'h20;
  localparam logic [7:0] payload_crc_fail_code    = 8'h40;
  localparam logic [7:0] header_crc_fail_code     = 8'h42;
  localparam logic [7:0] ack_seq_mismatch_code    = 8'h43;
  localparam logic [7:0] invalid_packet_type_code = 8'h44;

  // code table indexed by flag position, entry 0 in the low byte
  localparam logic [NUM_FAULTS-1:0][CODE_W-1:0] CODE_TABLE = {
    invalid_packet_type_code, ack_seq_mismatch_code, header_crc_fail_code,
    payload_crc_fail_code, missing_ack_code, reg_write_fail_code,
    host_out_overflow_code, host_in_overflow_code};

endpackage

// [verilog/fault_code_map.sv]
/*
  maps a vector of fault event pulses to the code that is stored.
  assumes the events come from logic on the same clock; when several
  fire together the highest flag position wins the code.
*/
`timescale 1ns/100ps

module fault_code_map
  import fault_alert_pkg::*;
(
  // fault events
  input  wire logic [NUM_FAULTS-1:0] event_v,
  // resulting code
  output logic      [CODE_W-1:0]     code,
  output logic                       any
);

  // -----------------------------------------------------------------
  // priority encode, later entries override earlier ones
  // -----------------------------------------------------------------
  always_comb begin
    code = '0;
    for (int i = 0; i < NUM_FAULTS; i++) begin
      if (event_v[i]) begin
        code = CODE_TABLE[i];
      end
    end
  end

  assign any = |event_v;

endmodule

// [verif/host_mcu_model.sv]
/*
  host microcontroller model: an avalon-mm master that reads and writes
  the fault registers and watches the alert line.
  assumes CLK from the bench and a slave that answers through waitrequest.
*/
`timescale 1ns/100ps

module host_mcu_model (
  // clock
  input  wire logic        clk,
  // avalon-mm master side
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [3:0]       avs_byteenable,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // alert line from the device, sampled at a falling clock edge
  input  wire logic        alert_line
);
  // -----------------------------------------------------------------
  // bus cycles
  // -----------------------------------------------------------------
  // idle bus at time zero
  initial begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata  = 32'h0;
  end

  // one transfer; the request holds until waitrequest is seen low,
  // released address and data lines then show inverted values so stale data never passes
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    avs_address    <= ~a;
    avs_writedata  <= ~d;
  endtask

  // alert level as the host sees it, taken once it has settled
  task automatic poll_alert(output logic s);
    @(negedge clk);
    s = alert_line;
  endtask
  // flag and enable scheme is the one a new host would use
endmodule

// [verif/radio_fault_alert_engine_tb.sv]
/*
  self-checking bench for the fault alert engine: reset values, standard
  flag scheme, legacy code mask with random masks and events.
  assumes the host model drives the register bus, the bench the events.
*/
`timescale 1ns/100ps

module radio_fault_alert_engine_tb;
  import fault_alert_pkg::*;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  logic                  clk;
  logic                  reset;
  logic [NUM_FAULTS-1:0] fault_event;
  logic [7:0]            address;
  logic                  rd_req, wr_req, waitreq, alert;
  logic [3:0]            be;
  logic [31:0]           wdata, rdata, q;
  logic [7:0]            mask;
  logic                  seen;             // alert level polled by the host
  int                    num_errors, n_checks, seed, b, b0;
  logic [7:0]            masks [6] = '{8'h10, 8'h60, 8'hff, 8'h08, 8'h20, 8'h40};

  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end

  // clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  radio_fault_alert_engine u_radio_fault_alert_engine (
    .CLK(clk), .RESET(reset), .FAULT_EVENT(fault_event), .AVS_ADDRESS(address), .AVS_READ(rd_req),
    .AVS_WRITE(wr_req), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .FAULT_ALERT_LINE(alert));

  host_mcu_model u_host_mcu_model (
    .clk(clk), .avs_address(address), .avs_read(rd_req), .avs_write(wr_req), .avs_byteenable(be),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq), .alert_line(alert));

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  // register access, ending where outputs have settled
  task automatic rd(input logic [7:0] a);
    u_host_mcu_model.xfer(1'b0, a, 32'h0, 4'hf, q);
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] e = 4'hf);
    u_host_mcu_model.xfer(1'b1, a, d, e, q);
    @(negedge clk);
  endtask
  // one-cycle fault pulse
  task automatic fire(input int i);
    @(posedge clk);
    fault_event <= 8'h01 << i;
    @(posedge clk);
    fault_event <= '0;
    @(negedge clk);
  endtask
  // expected legacy level after two faults under one mask
  function automatic logic exp_alert(input logic [7:0] m, input int f0, input int f1);
    return |((CODE_TABLE[f0] | CODE_TABLE[f1]) & m);
  endfunction
  // verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog well past the expected run time
  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    seed = 68765;
    reset = 1'b1;
    fault_event = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    // reset values and an unmapped address
    `CHK(alert, 1'b0)
    rd(FAULT_CODE_OFS); `CHK(q, 32'h0)
    rd(LEGACY_MASK_OFS); `CHK(q, 32'h0)
    rd(FLAG_BITS_OFS); `CHK(q, 32'h0)
    rd(FLAG_ENABLE_OFS); `CHK(q, 32'(FLAG_ENABLE_RST))
    rd(8'h14); `CHK(q, 32'h0)
    $display("test reset done");
    // standard scheme first, as a new host would use it; every condition in turn
    for (int i = 0; i < NUM_FAULTS; i++) begin
      fire(i);
      `CHK(alert, 1'b1)
      rd(FAULT_CODE_OFS); `CHK(q, 32'(CODE_TABLE[i]))
      rd(FLAG_BITS_OFS); `CHK(q, 32'h1 << i)
      rd(LINE_STATE_OFS); `CHK(q[LINE_ALERT_BIT], 1'b1)
      wr(FLAG_BITS_OFS, 32'h0); `CHK(alert, 1'b0)
    end
    // partial clears, enable changes, ignored byte lanes
    fire(0); fire(1);
    wr(FLAG_BITS_OFS, 32'hfe); `CHK(alert, 1'b1)
    rd(FLAG_BITS_OFS); `CHK(q, 32'h2)
    wr(FLAG_ENABLE_OFS, 32'h1); `CHK(alert, 1'b0)
    wr(FLAG_ENABLE_OFS, 32'hff); `CHK(alert, 1'b1)
    wr(FLAG_BITS_OFS, 32'h0, 4'he); `CHK(alert, 1'b1)
    wr(FLAG_BITS_OFS, 32'h0);
    $display("test standard done");
    // legacy scheme: fixed masks first, then random ones
    for (int k = 0; k < 16; k++) begin
      mask = (k < 6) ? masks[k] : 8'($random(seed)) | 8'h01;
      b0 = $unsigned($random(seed)) % NUM_FAULTS;
      b = $unsigned($random(seed)) % NUM_FAULTS;
      wr(LEGACY_MASK_OFS, 32'(mask));
      rd(FAULT_CODE_OFS);
      fire(b0); fire(b);
      `CHK(alert, exp_alert(mask, b0, b))
      rd(FAULT_CODE_OFS); `CHK(q, 32'(CODE_TABLE[b]))
      `CHK(alert, 1'b0)
    end
    // mask change and code writes leave the latched alert alone
    wr(LEGACY_MASK_OFS, 32'hff);
    fire(0);
    wr(LEGACY_MASK_OFS, 32'h10); `CHK(alert, 1'b1)
    wr(FAULT_CODE_OFS, 32'h0); `CHK(alert, 1'b1)
    rd(LINE_STATE_OFS); `CHK(q[LINE_ALERT_BIT], 1'b1)
    u_host_mcu_model.poll_alert(seen); `CHK(seen, 1'b1)
    rd(FAULT_CODE_OFS); `CHK(alert, 1'b0)
    wr(LEGACY_MASK_OFS, 32'h0); `CHK(alert, 1'b1)
    wr(FLAG_BITS_OFS, 32'h0); `CHK(alert, 1'b0)
    $display("test legacy done");
    finish_test();
  end
endmodule
